// [inc/pbt_regs.vh]
`ifndef PBT_REGS_VH
`define PBT_REGS_VH
// ==========================================
// training frame geometry
`define PBT_FRAME_WORDS 9'd348
`define PBT_WORD_SYMS 6'd46
`define PBT_CC_WORDS 9'd9
`define PBT_MARK_HALF 5'd23
`define PBT_OVH_START 6'd40
`define PBT_SYM_P1 2'b11
`define PBT_SYM_M1 2'b00
`define PBT_SYM_HOLD 2'b00
`define PBT_PRBS_SEED 13'h1fff
// ==========================================
// timing
`define PBT_CLK_NS 40
`define PBT_WAKE_NS 500
`define PBT_WAKE_CYC (`PBT_WAKE_NS / `PBT_CLK_NS)
// ==========================================
// register offsets
`define PBT_OFF_CTRL 8'h00
`define PBT_OFF_STAT 8'h04
`define PBT_OFF_TXCOEF 8'h08
`define PBT_OFF_TXSTAT 8'h0c
`define PBT_OFF_RXCOEF 8'h10
`define PBT_OFF_RXSTAT 8'h20
`define PBT_OFF_TAP 8'h30
`define PBT_CTRL_RST 32'h00000001
`define PBT_TAP_PRESET 6'h20
`define PBT_TAP_INIT 6'h10
// ==========================================
// control bit positions
`define PBT_B_TRAIN_OK 0
`define PBT_B_ALL_OFF 1
`define PBT_B_LANE_OFF 2
`define PBT_B_DS_EN 6
`define PBT_B_TX_MODE 7
`define PBT_B_RX_MODE 9
`define PBT_B_AUTO_OFF 11
`define PBT_B_LOOP 12
`define PBT_B_TRAIN_RUN 13
`define PBT_MODE_DATA 2'd0
`define PBT_MODE_QUIET 2'd1
`define PBT_MODE_ALERT 2'd2
`endif

// [logic/pbt_frame_tx.v]
`timescale 1ns/1ps
`default_nettype none
`include "pbt_regs.vh"
module pbt_frame_tx (
    input wire pclk,
    input wire presetn,
    input wire run,
    input wire [35:0] fld,
    output reg [1:0] sym_q
);
    reg [8:0] w_q;
    reg [5:0] s_q;
    reg lvl_q;
    reg [12:0] lf_q;
    wire [1:0] c = (s_q >= 6'd30) ? 2'd3 : (s_q >= 6'd20) ? 2'd2 : (s_q >= 6'd10) ? 2'd1 : 2'd0;
    wire ovh = s_q >= `PBT_OVH_START;
    wire [5:0] posw = ovh ? s_q - `PBT_OVH_START : s_q - {1'b0, c, 3'b000} - {3'b000, c, 1'b0};
    wire [5:0] idx = {w_q[3:0] - 4'd1, 2'b00} + {4'b0000, c};
    wire bitv = ovh | fld[6'd35 - idx]; // [R21] [R22]
    wire cc = (w_q != 9'd0) && (w_q <= `PBT_CC_WORDS);
    wire mid = posw == (ovh ? 6'd3 : 6'd5);
    wire lvl_d = (cc && (posw == 6'd0 || (mid && bitv))) ? ~lvl_q : lvl_q;
    // ==========================================
    // marker, dme control channel, prbs13 pattern
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            w_q <= 9'd0;
            s_q <= 6'd0;
            lvl_q <= 1'b0;
            lf_q <= `PBT_PRBS_SEED;
            sym_q <= `PBT_SYM_HOLD;
        end else if (!run) begin
            w_q <= 9'd0;
            s_q <= 6'd0;
            lvl_q <= 1'b0;
            sym_q <= `PBT_SYM_HOLD;
        end else begin
            if (s_q == `PBT_WORD_SYMS - 6'd1) begin
                s_q <= 6'd0;
                w_q <= (w_q == `PBT_FRAME_WORDS - 9'd1) ? 9'd0 : w_q + 9'd1; // [R16]
            end else begin
                s_q <= s_q + 6'd1;
            end
            lvl_q <= (w_q == 9'd0) ? 1'b0 : lvl_d;
            if (w_q == 9'd0) begin
                sym_q <= (s_q < {1'b0, `PBT_MARK_HALF}) ? `PBT_SYM_P1 : `PBT_SYM_M1; // [R17] [R25]
            end else if (cc) begin
                sym_q <= lvl_d ? `PBT_SYM_P1 : `PBT_SYM_M1; // [R18] [R20]
            end else begin
                lf_q <= {lf_q[11:0], lf_q[12] ^ lf_q[11] ^ lf_q[1] ^ lf_q[0]}; // [R23]
                sym_q <= lf_q[1:0];
            end
        end
    end
endmodule
`default_nettype wire

// [logic/pbt_frame_rx.v]
`timescale 1ns/1ps
`default_nettype none
`include "pbt_regs.vh"
module pbt_frame_rx (
    input wire pclk,
    input wire presetn,
    input wire [1:0] rx_sym,
    output reg [35:0] fld_q,
    output reg vld_q,
    output reg lock_q
);
    reg [8:0] w_q;
    reg [5:0] s_q;
    reg [4:0] pr_q;
    reg [4:0] mr_q;
    reg pok_q;
    reg a_q;
    reg p_q;
    reg viol_q;
    reg [35:0] sr_q;
    wire lv = rx_sym == `PBT_SYM_P1;
    wire lm = rx_sym == `PBT_SYM_M1;
    wire [1:0] c = (s_q >= 6'd30) ? 2'd3 : (s_q >= 6'd20) ? 2'd2 : (s_q >= 6'd10) ? 2'd1 : 2'd0;
    wire ovh = s_q >= `PBT_OVH_START;
    wire [5:0] posw = ovh ? s_q - `PBT_OVH_START : s_q - {1'b0, c, 3'b000} - {3'b000, c, 1'b0};
    wire cc = (w_q != 9'd0) && (w_q <= `PBT_CC_WORDS);
    wire h1 = posw == (ovh ? 6'd1 : 6'd2);
    wire h2 = posw == (ovh ? 6'd4 : 6'd7);
    wire mark = lm && pok_q && (mr_q == `PBT_MARK_HALF - 5'd1);
    wire bitv = a_q ^ lv;
    // ==========================================
    // marker search and dme cell decode
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            w_q <= 9'd0;
            s_q <= 6'd0;
            pr_q <= 5'd0;
            mr_q <= 5'd0;
            pok_q <= 1'b0;
            a_q <= 1'b0;
            p_q <= 1'b0;
            viol_q <= 1'b0;
            sr_q <= 36'h0;
            fld_q <= 36'h0;
            vld_q <= 1'b0;
            lock_q <= 1'b0;
        end else begin
            vld_q <= 1'b0;
            if (lv) begin
                pr_q <= (pr_q == `PBT_MARK_HALF) ? pr_q : pr_q + 5'd1;
                mr_q <= 5'd0;
                pok_q <= 1'b0;
            end else begin
                pr_q <= 5'd0;
                if (pr_q == `PBT_MARK_HALF) begin
                    pok_q <= lm;
                    mr_q <= 5'd1;
                end else begin
                    mr_q <= (pok_q && lm) ? mr_q + 5'd1 : 5'd0;
                    pok_q <= pok_q && lm;
                end
            end
            if (mark) begin
                lock_q <= 1'b1;
                w_q <= 9'd1;
                s_q <= 6'd0;
                p_q <= 1'b0;
                viol_q <= 1'b0;
                pok_q <= 1'b0;
            end else if (lock_q) begin
                if (s_q == `PBT_WORD_SYMS - 6'd1) begin
                    s_q <= 6'd0;
                    w_q <= (w_q == `PBT_FRAME_WORDS - 9'd1) ? 9'd0 : w_q + 9'd1;
                end else begin
                    s_q <= s_q + 6'd1;
                end
                if (cc && h1) begin
                    a_q <= lv;
                    if (lv == p_q)
                        viol_q <= 1'b1; // [R18]
                end
                if (cc && h2) begin
                    p_q <= lv;
                    if (ovh && !bitv)
                        viol_q <= 1'b1; // [R21]
                    if (!ovh)
                        sr_q <= {sr_q[34:0], bitv}; // [R20] [R22]
                end
                if (w_q == `PBT_CC_WORDS + 9'd1 && s_q == 6'd0 && !viol_q) begin
                    fld_q <= sr_q; // [R19]
                    vld_q <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [logic/pbt_ctl.v]
// Functional notes
// [R1] with deep sleep, wake mode sends alert frames back to back on every lane
// [R2] equalizer taps keep trained values whatever the transmit power state
// [R3] all_lanes_signal_ok is the AND of the four lane_signal_ok bits
// [R4] lane_signal_ok follows that lane's training signal detect variable
// [R5] training not allowed forces all four lane_signal_ok to one
// [R6] deep sleep: lane_signal_ok clears when receive state first enters quiet
// [R7] in quiet, lane_signal_ok rises within 500 ns of a valid wake pattern
// [R8] in quiet, lane_signal_ok stays low while far transmitter is disabled
// [R9] all_tx_off makes all four transmitters hold a constant level
// [R10] a combined fault may set all_tx_off
// [R11] loopback works regardless of transmit-off controls and leaves transmitter alone
// [R12] deep sleep: transmitters off on entering quiet, back on when leaving
// [R13] lane_tx_off stops only that lane's transmitter at a constant level
// [R14] combined_fault is OR of receive, transmit and implementation faults
// [R15] all_tx_off is no transmit fault; a transmit fault should raise it
// [R16] a frame is 348 words of 46 symbols, sent back to back
// [R17] frame starts with 23 plus-one then 23 minus-one symbols
// [R18] control bits use differential manchester cells of +1/-1 runs
// [R19] any coding violation discards the whole control channel of that frame
// [R20] control channel is 9 words of four 10-symbol cells plus 6-symbol overhead
// [R21] every overhead cell encodes a one
// [R22] coefficient update in first 16 cells from cell 15; status after, from cell 19
// [R23] remaining 338 words carry a prbs13 pattern
// [R24] each of three taps has a 2-bit increment, decrement or hold code
// [R25] marker first, then nine control words, then pattern words
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pbt_regs.vh"
module pbt_ctl #(
    parameter NFLT = 2
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [3:0] lane_sig_det,
    input wire [3:0] lane_rx_alert,
    input wire rx_side_fault,
    input wire tx_side_fault,
    input wire [NFLT-1:0] impl_fault,
    input wire [7:0] pma_tx_sym,
    input wire [7:0] line_rx_sym,
    output reg [7:0] line_tx_sym,
    output reg [7:0] pma_rx_sym,
    output reg [3:0] lane_signal_ok,
    output reg all_lanes_signal_ok,
    output reg combined_fault
);
    // ==========================================
    // registers
    reg [31:0] ctrl_q;
    reg [15:0] txcoef_q;
    reg [17:0] txstat_q;
    reg [1:0] rxm_q;
    reg [1:0] txm_q;
    reg quiet_off_q;
    reg txf_q;
    reg rxf_q;
    wire [3:0] ok_d;
    wire [3:0] lock;
    wire [71:0] tap_all;
    wire [63:0] rxcoef_all;
    wire [79:0] rxstat_all;
    wire [7:0] gen_sym;
    wire train_ok = ctrl_q[`PBT_B_TRAIN_OK];
    wire ds_en = ctrl_q[`PBT_B_DS_EN];
    wire [1:0] tx_mode = ctrl_q[`PBT_B_TX_MODE+:2];
    wire [1:0] rx_mode = ctrl_q[`PBT_B_RX_MODE+:2];
    wire run_train = ctrl_q[`PBT_B_TRAIN_RUN];
    wire alert = ds_en && tx_mode == `PBT_MODE_ALERT;
    wire gen_run = run_train | alert; // [R1]
    wire rx_quiet = ds_en && rx_mode == `PBT_MODE_QUIET;
    wire rx_quiet_entry = rx_quiet && rxm_q != `PBT_MODE_QUIET;
    wire tx_quiet = ds_en && tx_mode == `PBT_MODE_QUIET;
    wire fault_d = rx_side_fault | tx_side_fault | (|impl_fault); // [R14]
    wire apb_acc = psel && penable && pready;
    wire apb_wr = apb_acc && pwrite && !pslverr;
    // ==========================================
    // outgoing control channel fields
    wire [15:0] coef_tx = {txcoef_q[15:7], ^{txcoef_q[15:7], txcoef_q[5:0]}, txcoef_q[5:0]};
    wire [18:0] stat_low = {alert, txstat_q[17:0]};
    wire [35:0] cc_fld = {coef_tx, ^stat_low, stat_low}; // [R22]
    function [5:0] tap_step;
        input [5:0] t;
        input [1:0] code;
        begin
            tap_step = t;
            if (code == 2'b01 && t != 6'h3f)
                tap_step = t + 6'd1;
            else if (code == 2'b10 && t != 6'h00)
                tap_step = t - 6'd1;
        end
    endfunction
    function map_ok;
        input [7:0] a;
        begin
            map_ok = (a[7:6] == 2'b00) && (a[1:0] == 2'b00);
        end
    endfunction
    // ==========================================
    // per lane logic
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_lane
            reg [3:0] wc_q;
            reg [17:0] tap_q;
            reg [15:0] rc_q;
            reg [19:0] rs_q;
            reg ok_r;
            wire [35:0] rfld;
            wire rvld;
            wire off = ctrl_q[`PBT_B_ALL_OFF] | ctrl_q[`PBT_B_LANE_OFF + i] | quiet_off_q;
            wire [1:0] src = gen_run ? gen_sym[2*i+:2] : pma_tx_sym[2*i+:2];
            wire par_ok = ~^rfld[35:20];
            pbt_frame_tx u_tx (
                .pclk(pclk),
                .presetn(presetn),
                .run(gen_run),
                .fld(cc_fld),
                .sym_q(gen_sym[2*i+:2])
            );
            pbt_frame_rx u_rx (
                .pclk(pclk),
                .presetn(presetn),
                .rx_sym(line_rx_sym[2*i+:2]),
                .fld_q(rfld),
                .vld_q(rvld),
                .lock_q(lock[i])
            );
            assign ok_d[i] = !train_ok ? 1'b1 : // [R5]
                rx_quiet_entry ? 1'b0 : // [R6]
                rx_quiet ? (ok_r | (wc_q >= `PBT_WAKE_CYC - 1)) : // [R7] [R8]
                lane_sig_det[i]; // [R4]
            assign tap_all[18*i+:18] = tap_q;
            assign rxcoef_all[16*i+:16] = rc_q;
            assign rxstat_all[20*i+:20] = rs_q;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    wc_q <= 4'd0;
                    tap_q <= {3{`PBT_TAP_INIT}};
                    rc_q <= 16'h0;
                    rs_q <= 20'h0;
                    ok_r <= 1'b0;
                    line_tx_sym[2*i+:2] <= `PBT_SYM_HOLD;
                    pma_rx_sym[2*i+:2] <= `PBT_SYM_HOLD;
                end else begin
                    ok_r <= ok_d[i];
                    if (rx_quiet && lane_rx_alert[i] && wc_q != 4'hf)
                        wc_q <= wc_q + 4'd1;
                    else if (!lane_rx_alert[i])
                        wc_q <= 4'd0;
                    line_tx_sym[2*i+:2] <= off ? `PBT_SYM_HOLD : src; // [R9] [R13]
                    pma_rx_sym[2*i+:2] <= ctrl_q[`PBT_B_LOOP] ? src : line_rx_sym[2*i+:2]; // [R11]
                    if (rvld) begin
                        rs_q <= rfld[19:0];
                        rc_q <= rfld[35:20];
                    end
                    if (rvld && par_ok && run_train) begin // [R2]
                        if (rfld[33])
                            tap_q <= {3{`PBT_TAP_PRESET}};
                        else if (rfld[32])
                            tap_q <= {3{`PBT_TAP_INIT}};
                        else begin
                            tap_q[17:12] <= tap_step(tap_q[17:12], rfld[25:24]); // [R24]
                            tap_q[11:6] <= tap_step(tap_q[11:6], rfld[23:22]);
                            tap_q[5:0] <= tap_step(tap_q[5:0], rfld[21:20]);
                        end
                    end
                end
            end
        end
    endgenerate
    // ==========================================
    // status, power states and fault
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxm_q <= `PBT_MODE_DATA;
            txm_q <= `PBT_MODE_DATA;
            quiet_off_q <= 1'b0;
            lane_signal_ok <= 4'h0;
            all_lanes_signal_ok <= 1'b0;
            combined_fault <= 1'b0;
            txf_q <= 1'b0;
            rxf_q <= 1'b0;
        end else begin
            rxm_q <= rx_mode;
            txm_q <= tx_mode;
            if (tx_quiet && txm_q != `PBT_MODE_QUIET)
                quiet_off_q <= 1'b1; // [R12]
            else if (!tx_quiet)
                quiet_off_q <= 1'b0; // [R12]
            lane_signal_ok <= ok_d;
            all_lanes_signal_ok <= &ok_d; // [R3]
            combined_fault <= fault_d;
            txf_q <= tx_side_fault;
            rxf_q <= rx_side_fault;
        end
    end
    // ==========================================
    // apb slave
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `PBT_CTRL_RST;
            txcoef_q <= 16'h0;
            txstat_q <= 18'h0;
        end else begin
            if (apb_wr) begin
                case (paddr)
                    `PBT_OFF_CTRL: ctrl_q <= {18'h0, pwdata[13:0]};
                    `PBT_OFF_TXCOEF: txcoef_q <= pwdata[15:0];
                    `PBT_OFF_TXSTAT: txstat_q <= pwdata[17:0];
                    default: ctrl_q <= ctrl_q;
                endcase
            end
            if (ctrl_q[`PBT_B_AUTO_OFF] && (combined_fault | tx_side_fault))
                ctrl_q[`PBT_B_ALL_OFF] <= 1'b1; // [R10] [R15]
        end
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= psel && penable && !pready;
            if (psel && penable && !pready) begin
                pslverr <= !map_ok(paddr);
                prdata <= 32'h0;
                if (!pwrite && map_ok(paddr)) begin
                    case (paddr[5:2])
                        4'h0: prdata <= ctrl_q;
                        4'h1: prdata <= {20'h0, lock, rxf_q, txf_q, combined_fault,
                            all_lanes_signal_ok, lane_signal_ok};
                        4'h2: prdata <= {16'h0, txcoef_q};
                        4'h3: prdata <= {14'h0, txstat_q};
                        4'h4, 4'h5, 4'h6, 4'h7: prdata <= {16'h0, rxcoef_all[16*paddr[3:2]+:16]};
                        4'h8, 4'h9, 4'ha, 4'hb: prdata <= {12'h0, rxstat_all[20*paddr[3:2]+:20]};
                        4'hc, 4'hd, 4'he, 4'hf: prdata <= {14'h0, tap_all[18*paddr[3:2]+:18]};
                        default: prdata <= 32'h0;
                    endcase
                end
            end
        end
    end
endmodule
`default_nettype wire

// [verif/pbt_ctl_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module pbt_ctl_chk #(
    parameter NFLT = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic [3:0] lane_signal_ok,
    input wire logic all_lanes_signal_ok,
    input wire logic combined_fault,
    input wire logic rx_side_fault,
    input wire logic tx_side_fault,
    input wire logic [NFLT-1:0] impl_fault,
    input wire logic [7:0] line_tx_sym
);
    // ======================================
    // lane 0 frame position tracker
    logic [4:0] one_q;
    logic [15:0] gap_q;
    logic [8:0] w_q;
    logic [5:0] s_q;
    logic syn_q;
    wire logic [1:0] l0 = line_tx_sym[1:0];
    wire logic mk = one_q == 5'd23 && l0 == 2'b00;
    wire logic cc = syn_q && w_q >= 9'd1 && w_q <= 9'd9;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            one_q <= 5'h0;
            gap_q <= 16'h0;
            w_q <= 9'h0;
            s_q <= 6'h0;
            syn_q <= 1'b0;
        end else begin
            one_q <= (l0 != 2'b11) ? 5'h0 : (one_q == 5'h1f) ? one_q : one_q + 5'h1;
            if (mk) begin
                gap_q <= 16'h0;
                syn_q <= 1'b1;
                w_q <= 9'h0;
                s_q <= 6'd24;
            end else begin
                gap_q <= gap_q + 16'h1;
                // a stopped generator restarts its frame, so stop judging the gap
                syn_q <= syn_q && gap_q != 16'd20000;
                s_q <= (s_q == 6'd45) ? 6'h0 : s_q + 6'h1;
                w_q <= (s_q == 6'd45) ? w_q + 9'h1 : w_q;
            end
        end
    end
    // ======================================
    // properties
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_lanes_and: assert property (all_lanes_signal_ok == &lane_signal_ok)
        else $error("all lanes ok is not the and of the lanes");
    chk_fault_or: assert property (combined_fault ==
        ($past(rx_side_fault) | $past(tx_side_fault) | (|$past(impl_fault))))
        else $error("combined fault is not the or of its sources");
    chk_mark_run: assert property (one_q <= 5'd23)
        else $error("run of plus one symbols too long");
    chk_mark_low: assert property (mk |=> (l0 == 2'b00) [*8] ##1 (l0 == 2'b00) [*8]
        ##1 (l0 == 2'b00) [*6] ##1 l0 == 2'b11)
        else $error("marker low half or control start wrong");
    chk_frame_gap: assert property (mk && syn_q |-> gap_q == 16'd16007)
        else $error("frame length wrong");
    chk_cell_edge: assert property (cc && s_q % 10 == 0 |-> l0 != $past(l0))
        else $error("no transition at cell boundary");
    chk_ovh_one: assert property (cc && s_q == 6'd43 |-> l0 != $past(l0))
        else $error("overhead cell not a one");
    chk_ovh_flat: assert property (cc && s_q > 6'd40 && s_q != 6'd43 |-> l0 == $past(l0))
        else $error("overhead cell has extra transition");
    chk_apb_pulse: assert property (pready |-> psel && penable ##1 !pready)
        else $error("pready outside access or longer than one cycle");
    cover property (mk && syn_q);
    cover property (cc && s_q == 6'd43);
    cover property ($rose(combined_fault));
endmodule
bind pbt_ctl pbt_ctl_chk #(.NFLT(NFLT)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .lane_signal_ok(lane_signal_ok),
    .all_lanes_signal_ok(all_lanes_signal_ok), .combined_fault(combined_fault), .rx_side_fault(rx_side_fault),
    .tx_side_fault(tx_side_fault), .impl_fault(impl_fault), .line_tx_sym(line_tx_sym));
`default_nettype wire

// [verif/pbt_far_end.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pbt_regs.vh"
module pbt_far_end (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic bad,
    input wire logic [35:0] fld,
    output logic [7:0] sym
);
    logic [8:0] w_q;
    logic [5:0] s_q;
    logic lvl_q;
    logic [12:0] prbs_q;
    logic nl;
    int bi;
    // ======================================
    // level of the next control channel symbol
    always_comb begin
        bi = 35 - (int'(w_q) - 1) * 4 - int'(s_q) / 10;
        nl = lvl_q ^ (s_q % 10 == 0 && !(bad && w_q == 9'd1 && s_q == 6'd10));
        nl = nl ^ (s_q < 6'd40 ? s_q % 10 == 5 && fld[bi] : s_q == 6'd43);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            w_q <= 9'h0;
            s_q <= 6'h0;
            lvl_q <= 1'b0;
            prbs_q <= `PBT_PRBS_SEED;
            sym <= 8'h00;
        end else if (!run) begin
            // idle line keeps changing so stale symbols never look valid
            w_q <= 9'h0;
            s_q <= 6'h0;
            sym <= ~sym;
        end else begin
            s_q <= (s_q == 6'd45) ? 6'h0 : s_q + 6'h1;
            if (s_q == 6'd45) begin
                w_q <= (w_q == 9'd347) ? 9'h0 : w_q + 9'h1;
            end
            if (w_q == 9'h0) begin
                sym <= {8{s_q < `PBT_MARK_HALF}};
                lvl_q <= 1'b0;
            end else if (w_q <= `PBT_CC_WORDS) begin
                sym <= {8{nl}};
                lvl_q <= nl;
            end else begin
                sym <= {8{prbs_q[12]}};
                prbs_q <= {prbs_q[11:0], prbs_q[12] ^ prbs_q[11] ^ prbs_q[1] ^ prbs_q[0]};
            end
        end
    end
endmodule
`default_nettype wire

// [verif/pbt_ctl_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pbt_regs.vh"
module pbt_ctl_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] lane_sig_det = 4'h0;
    logic [3:0] lane_rx_alert = 4'h0;
    logic rx_side_fault = 1'b0;
    logic tx_side_fault = 1'b0;
    logic [1:0] impl_fault = 2'h0;
    logic [7:0] pma_tx_sym = 8'he6;
    logic far_run = 1'b0;
    logic far_bad = 1'b0;
    logic [35:0] far_fld = 36'h0;
    logic [31:0] rdat;
    logic rerr;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, all_lanes_signal_ok, combined_fault;
    wire logic [7:0] line_rx_sym, line_tx_sym, pma_rx_sym;
    wire logic [3:0] lane_signal_ok;
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;
    localparam logic [35:0] FA = {16'h0041, 20'h00050};
    localparam logic [35:0] FB = {16'h0012, 20'h00011};
    localparam logic [31:0] TAPR = 32'h00010410;
    pbt_ctl #(.NFLT(2)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .lane_sig_det, .lane_rx_alert, .rx_side_fault, .tx_side_fault, .impl_fault, .pma_tx_sym,
        .line_rx_sym, .line_tx_sym, .pma_rx_sym, .lane_signal_ok, .all_lanes_signal_ok, .combined_fault);
    pbt_far_end far (.pclk(pclk), .presetn(presetn), .run(far_run), .bad(far_bad), .fld(far_fld),
        .sym(line_rx_sym));
    // ======================================
    // clock, timeout and tasks
    initial forever #20 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            give_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) chk(32'h0, 32'h1);
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    task automatic fields(input logic [35:0] f);
        for (int i = 0; i < 4; i++) begin
            rd(`PBT_OFF_RXCOEF + 8'(4 * i), {16'h0, f[35:20]});
            rd(`PBT_OFF_RXSTAT + 8'(4 * i), {12'h0, f[19:0]});
        end
    endtask
    task automatic note(input string s);
        $display("test %s done", s);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ======================================
    // main sequence
    initial begin
        tick(6);
        presetn <= 1'b1;
        tick(1);
        rd(`PBT_OFF_CTRL, `PBT_CTRL_RST);
        rd(`PBT_OFF_TAP, TAPR);
        apb(1'b0, 8'hc0, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        chk(rdat, 32'h0);
        note("reset");
        lane_sig_det <= 4'hb;
        tick(3);
        chk(lane_signal_ok, 32'hb);
        chk(all_lanes_signal_ok, 32'h0);
        lane_sig_det <= 4'hf;
        tick(3);
        chk(all_lanes_signal_ok, 32'h1);
        lane_sig_det <= 4'h0;
        wr(`PBT_OFF_CTRL, 32'h0);
        tick(2);
        chk(lane_signal_ok, 32'hf);
        wr(`PBT_OFF_CTRL, 32'h1);
        lane_sig_det <= 4'hf;
        note("signal ok");
        for (int i = 0; i < 4; i++) begin
            {impl_fault, tx_side_fault, rx_side_fault} <= 4'h1 << i;
            tick(3);
            chk(combined_fault, 32'h1);
            {impl_fault, tx_side_fault, rx_side_fault} <= 4'h0;
            tick(3);
            chk(combined_fault, 32'h0);
        end
        wr(`PBT_OFF_CTRL, 32'h801);
        tx_side_fault <= 1'b1;
        tick(3);
        tx_side_fault <= 1'b0;
        rd(`PBT_OFF_CTRL, 32'h803);
        chk(line_tx_sym, 32'h0);
        wr(`PBT_OFF_CTRL, 32'h1003);
        tick(4);
        chk(line_tx_sym, 32'h0);
        chk(pma_rx_sym, 32'he6);
        wr(`PBT_OFF_CTRL, 32'h5);
        tick(4);
        chk(line_tx_sym, 32'he4);
        note("tx off");
        wr(`PBT_OFF_CTRL, 32'hc1);
        tick(4);
        chk(line_tx_sym, 32'h0);
        wr(`PBT_OFF_CTRL, 32'h241);
        tick(4);
        chk(line_tx_sym, 32'he6);
        chk(lane_signal_ok, 32'h0);
        lane_rx_alert <= 4'h4;
        tick(13);
        chk(lane_signal_ok, 32'h4);
        lane_rx_alert <= 4'h0;
        note("deep sleep");
        far_fld <= FA;
        far_run <= 1'b1;
        wr(`PBT_OFF_CTRL, 32'h141);
        tick(17000);
        fields(FA);
        far_bad <= 1'b1;
        far_fld <= FB;
        tick(17000);
        fields(FA);
        rd(`PBT_OFF_TAP, TAPR);
        far_bad <= 1'b0;
        far_fld <= FA;
        wr(`PBT_OFF_CTRL, 32'h2141);
        tick(16008);
        rd(`PBT_OFF_TAP, TAPR + 32'h1);
        note("frames");
        give_verdict();
    end
endmodule
`default_nettype wire
